//--- src/mtf_xlate.sv
/*
  Effective-to-physical translation with block map, segments, two TLBs,
  table-walk refill and fault cause reporting.
  Assumes the core holds off new accesses while busy_o is high and that
  the table walker runs on clk_i.
*/
// Added by the designer: the plain strobed port and the placing of the registers.
// Functional notes
// - Translation off for the access kind: physical address equals effective address.
// - Block hit is checked against its protection bits; violation faults fetch or data.
// - No block match: top four effective address bits pick one of 16 segments.
// - Segment direct-store bit clear selects paging; set is unsupported and faults.
// - Paging forms a 52-bit virtual address from segment and effective address.
// - Two TLBs, one for fetches and one for data accesses.
// - TLB hit forwards the translated physical page number to memory.
// - TLB miss walks the page table, fills an entry, and retries to a hit.
// - Found page translation is checked against page protection bits.
// - No page entry and no block: page fault, cause bit 1 set.
// - Block or page protection violation sets cause bit 4.
// - Fetch through no-execute segment faults with status bit 3.
// - Fetch through direct-store segment faults with status bit 3.
// - Load or store to a direct-store segment with no block match faults with cause bit 5.
// - Fetch from guarded block or guarded page faults with status bit 3.
// - With data translation off, no translation fault is raised for data.
// - Every translation fault records the failing instruction address.
// - Block match wins; the parallel page result is discarded.
// - Store hit on clean page sets changed bit in TLB and table.
`timescale 1ns/10ps
`default_nettype none
`include "mtf_defines.svh"

module mtf_xlate
  import mtf_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        instr_xlate_enable_i,
  input  wire logic        data_xlate_enable_i,
  input  wire logic        req_valid_i,
  input  wire logic        req_fetch_i,
  input  wire logic        req_store_i,
  input  wire logic        req_user_i,
  input  wire logic [31:0] req_effective_addr_i,
  input  wire logic [31:0] req_instr_addr_i,
  output logic             busy_o,
  output logic             resp_valid_o,
  output logic [31:0]      resp_pa_o,
  output logic             resp_instr_storage_fault_o,
  output logic             resp_data_storage_fault_o,
  output logic             walk_req_o,
  output logic [51:0]      walk_va_o,
  input  wire logic        walk_done_i,
  input  wire logic        walk_found_i,
  input  wire logic [19:0] walk_rpn_i,
  input  wire logic [1:0]  walk_pp_i,
  input  wire logic        walk_g_i,
  input  wire logic        walk_c_i,
  output logic             chg_wr_o,
  output logic [51:0]      chg_va_o,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [31:0]      reg_rdata_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Protection helpers

  // Block match on the unmasked upper bits, gated by the mode valid bit
  function automatic logic bat_match(input logic [31:0] up, input logic [31:0] ea,
                                     input logic user);
    logic [14:0] msk;
    msk = {4'h0, up[12:2]};
    return ((ea[31:17] & ~msk) == (up[31:17] & ~msk)) &&
           (user ? up[`MTF_BLK_VP] : up[`MTF_BLK_VS]);
  endfunction

  // Block pp: 00 no access, x1 read-only, 10 read-write
  function automatic logic bat_viol(input logic [1:0] pp, input logic wr);
    return (pp == 2'b00) || (pp[0] && wr);
  endfunction

  // Page pp qualified by the segment key of the current mode
  function automatic logic page_viol(input logic key, input logic [1:0] pp,
                                     input logic wr);
    return key ? ((pp == 2'b00) || (pp != 2'b10 && wr)) : (pp == 2'b11 && wr);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  mtf_state_t  state_q;
  logic [31:0] sr_q [16];
  logic [31:0] bat_q [2][4];   // [side][{entry, lower}]
  mtf_tlb_t    tlb_q [2][4];   // [0] fetch TLB, [1] data TLB
  logic [1:0]  fill_ptr_q [2];
  logic        held_fetch_q, held_store_q, held_user_q;
  logic [31:0] held_ea_q, held_cia_q;
  logic [31:0] srs_q, dfc_q, fault_iaddr_q, fault_ea_q;

  ////////////////////////////////////////////////////////////////////////////
  // Translation path

  logic        acc, in_idle, cur_fetch, cur_store, cur_user, xen, side;
  logic [31:0] cur_ea, cur_cia, sr, x_pa, x_srs, x_dfc;
  logic        bat_hit, x_fault, x_miss, x_chg;
  logic [1:0]  bat_pp, hit_idx;
  logic        bat_g, tlb_hit, key;
  logic [31:0] bat_lo;
  logic [14:0] bat_msk;
  logic [31:0] srs_cl, dfc_cl;
  logic [51:0] va;
  mtf_tlb_t    hit_e;

  assign in_idle   = (state_q == MTF_IDLE);
  assign acc       = req_valid_i && in_idle && ce_i;
  // Live inputs on a fresh access, held copy on the retry after a walk
  assign cur_fetch = in_idle ? req_fetch_i : held_fetch_q;
  assign cur_store = in_idle ? req_store_i : held_store_q;
  assign cur_user  = in_idle ? req_user_i : held_user_q;
  assign cur_ea    = in_idle ? req_effective_addr_i : held_ea_q;
  assign cur_cia   = in_idle ? req_instr_addr_i : held_cia_q;
  assign side      = ~cur_fetch;
  assign xen       = cur_fetch ? instr_xlate_enable_i : data_xlate_enable_i;
  assign sr        = sr_q[cur_ea[31:28]];
  assign va        = {sr[23:0], cur_ea[27:0]};
  assign key       = cur_user ? sr[`MTF_SEG_KP] : sr[`MTF_SEG_KS];

  // Block array search, lowest entry wins
  always_comb begin
    bat_hit = 1'b0;
    bat_lo  = 32'h0;
    bat_msk = 15'h0;
    for (int i = 1; i >= 0; i--) begin
      if (bat_match(bat_q[side][2*i], cur_ea, cur_user)) begin
        bat_hit = 1'b1;
        bat_lo  = bat_q[side][2*i+1];
        bat_msk = {4'h0, bat_q[side][2*i][12:2]};  // Length mask of the winner
      end
    end
    bat_pp = bat_lo[1:0];
    bat_g  = bat_lo[`MTF_BLK_G];
  end

  // TLB search in the TLB of the access kind
  always_comb begin
    tlb_hit = 1'b0;
    hit_idx = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (tlb_q[side][i].valid && tlb_q[side][i].tag == va[51:12]) begin
        tlb_hit = 1'b1;
        hit_idx = 2'(i);
      end
    end
    hit_e = tlb_q[side][hit_idx];
  end

  // Outcome of one access: address, cause bits, miss and changed-bit update
  always_comb begin
    x_pa   = cur_ea;
    x_srs  = 32'h0;
    x_dfc  = 32'h0;
    x_miss = 1'b0;
    x_chg  = 1'b0;
    if (!xen) begin
      x_pa = cur_ea;
    end else if (bat_hit) begin
      // Page result is simply not consulted here
      x_pa = {bat_lo[31:17] | (cur_ea[31:17] & bat_msk),
              cur_ea[16:0]};
      if (bat_viol(bat_pp, cur_store)) begin
        x_srs[`MTF_CAUSE_PROT] = cur_fetch;
        x_dfc[`MTF_CAUSE_PROT] = ~cur_fetch;
      end
      if (cur_fetch && bat_g) x_srs[`MTF_CAUSE_NOEXEC] = 1'b1;
    end else if (sr[`MTF_SEG_T]) begin
      // Direct-store segments are not supported
      x_srs[`MTF_CAUSE_NOEXEC] = cur_fetch;
      x_dfc[`MTF_CAUSE_DSTORE] = ~cur_fetch;
    end else if (cur_fetch && sr[`MTF_SEG_N]) begin
      x_srs[`MTF_CAUSE_NOEXEC] = 1'b1;
    end else if (!tlb_hit) begin
      x_miss = 1'b1;
    end else begin
      x_pa = {hit_e.rpn, cur_ea[11:0]};
      if (page_viol(key, hit_e.pp, cur_store)) begin
        x_srs[`MTF_CAUSE_PROT] = cur_fetch;
        x_dfc[`MTF_CAUSE_PROT] = ~cur_fetch;
      end
      if (cur_fetch && hit_e.g) x_srs[`MTF_CAUSE_NOEXEC] = 1'b1;
    end
    x_fault = (x_srs != 32'h0) || (x_dfc != 32'h0);
    if (!x_fault && !x_miss && xen && !bat_hit && cur_store && !hit_e.c)
      x_chg = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and responses

  logic finish, walk_miss, walk_fill;
  assign finish    = (acc && !x_miss) || (state_q == MTF_RETRY && ce_i);
  assign walk_miss = (state_q == MTF_WALK) && walk_done_i && !walk_found_i && ce_i;
  assign walk_fill = (state_q == MTF_WALK) && walk_done_i && walk_found_i && ce_i;

  // Walk sequencing; the core stays stalled until retry or fault
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= MTF_IDLE;
      busy_o  <= 1'b0;
    end else if (ce_i) begin
      unique case (state_q)
        MTF_IDLE: begin
          if (acc && x_miss) begin
            state_q <= MTF_WALK;
            busy_o  <= 1'b1;
          end
        end
        MTF_WALK: begin
          if (walk_done_i) begin
            state_q <= walk_found_i ? MTF_RETRY : MTF_IDLE;
            busy_o  <= walk_found_i;
          end
        end
        MTF_RETRY: begin
          state_q <= MTF_IDLE;
          busy_o  <= 1'b0;
        end
        default: begin
          state_q <= MTF_IDLE;
          busy_o  <= 1'b0;
        end
      endcase
    end
  end

  // Request copy for the walk and the retry
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      held_fetch_q <= 1'b0;
      held_store_q <= 1'b0;
      held_user_q  <= 1'b0;
      held_ea_q    <= 32'h0;
      held_cia_q   <= 32'h0;
    end else if (acc) begin
      held_fetch_q <= req_fetch_i;
      held_store_q <= req_store_i;
      held_user_q  <= req_user_i;
      held_ea_q    <= req_effective_addr_i;
      held_cia_q   <= req_instr_addr_i;
    end
  end

  // Walk request stands from the miss until the walker answers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      walk_req_o <= 1'b0;
      walk_va_o  <= 52'h0;
    end else if (ce_i) begin
      if (acc && x_miss) begin
        walk_req_o <= 1'b1;
        walk_va_o  <= va;
      end else if (walk_done_i) begin
        walk_req_o <= 1'b0;
      end
    end
  end

  // One-cycle answer to the core; a failed walk answers as page fault
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      resp_valid_o               <= 1'b0;
      resp_pa_o                  <= 32'h0;
      resp_instr_storage_fault_o <= 1'b0;
      resp_data_storage_fault_o  <= 1'b0;
      chg_wr_o                   <= 1'b0;
      chg_va_o                   <= 52'h0;
    end else if (ce_i) begin
      resp_valid_o               <= finish || walk_miss;
      resp_pa_o                  <= x_pa;
      resp_instr_storage_fault_o <= (finish && x_fault && cur_fetch) ||
                                    (walk_miss && held_fetch_q);
      resp_data_storage_fault_o  <= (finish && x_fault && !cur_fetch) ||
                                    (walk_miss && !held_fetch_q);
      chg_wr_o                   <= finish && x_chg;
      chg_va_o                   <= va;
    end
  end

  // TLB fill on a found entry, changed bit on a clean store hit
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int s = 0; s < 2; s++) begin
        fill_ptr_q[s] <= 2'h0;
        for (int i = 0; i < 4; i++) tlb_q[s][i] <= '0;
      end
    end else if (ce_i) begin
      if (walk_fill) begin
        tlb_q[side][fill_ptr_q[side]] <= '{valid: 1'b1, tag: va[51:12],
                                           rpn: walk_rpn_i, pp: walk_pp_i,
                                           g: walk_g_i, c: walk_c_i};
        fill_ptr_q[side] <= fill_ptr_q[side] + 2'h1;  // Round-robin victim
      end else if (finish && x_chg) begin
        tlb_q[side][hit_idx].c <= 1'b1;
      end
    end
  end

  // Write-one-to-clear view; a fault in the same cycle is ORed on top
  assign srs_cl = (reg_wr_i && reg_addr_i == `MTF_ADDR_SRS) ? (srs_q & ~reg_wdata_i) : srs_q;
  assign dfc_cl = (reg_wr_i && reg_addr_i == `MTF_ADDR_DFC) ? (dfc_q & ~reg_wdata_i) : dfc_q;

  // Cause bits and fault addresses; a new fault wins over a clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      srs_q         <= 32'h0;
      dfc_q         <= 32'h0;
      fault_iaddr_q <= 32'h0;
      fault_ea_q    <= 32'h0;
    end else if (ce_i) begin
      srs_q <= srs_cl;
      dfc_q <= dfc_cl;
      if (finish && x_fault) begin
        srs_q         <= srs_cl | x_srs;
        dfc_q         <= dfc_cl | x_dfc;
        fault_iaddr_q <= cur_cia;
        fault_ea_q    <= cur_ea;
      end else if (walk_miss) begin
        srs_q[`MTF_CAUSE_PGFLT] <= srs_cl[`MTF_CAUSE_PGFLT] | held_fetch_q;
        dfc_q[`MTF_CAUSE_PGFLT] <= dfc_cl[`MTF_CAUSE_PGFLT] | ~held_fetch_q;
        fault_iaddr_q           <= held_cia_q;
        fault_ea_q              <= held_ea_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  // Segment and block writes; loaded in any state, including during a walk
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) sr_q[i] <= 32'h0;
      for (int s = 0; s < 2; s++) begin
        for (int i = 0; i < 4; i++) bat_q[s][i] <= 32'h0;
      end
    end else if (ce_i && reg_wr_i) begin
      if (reg_addr_i[7:6] == 2'b00) sr_q[reg_addr_i[5:2]] <= reg_wdata_i;
      if ((reg_addr_i & `MTF_ADDR_BANK_MASK) == `MTF_ADDR_IBAT_BASE)
        bat_q[0][reg_addr_i[3:2]] <= reg_wdata_i;
      if ((reg_addr_i & `MTF_ADDR_BANK_MASK) == `MTF_ADDR_DBAT_BASE)
        bat_q[1][reg_addr_i[3:2]] <= reg_wdata_i;
    end
  end

  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0;
    end else if (ce_i) begin
      reg_rdata_o <= 32'h0;
      if (reg_rd_i) begin
        if (reg_addr_i[7:6] == 2'b00) reg_rdata_o <= sr_q[reg_addr_i[5:2]];
        else if ((reg_addr_i & `MTF_ADDR_BANK_MASK) == `MTF_ADDR_IBAT_BASE)
          reg_rdata_o <= bat_q[0][reg_addr_i[3:2]];
        else if ((reg_addr_i & `MTF_ADDR_BANK_MASK) == `MTF_ADDR_DBAT_BASE)
          reg_rdata_o <= bat_q[1][reg_addr_i[3:2]];
        else if (reg_addr_i == `MTF_ADDR_SRS) reg_rdata_o <= srs_q;
        else if (reg_addr_i == `MTF_ADDR_DFC) reg_rdata_o <= dfc_q;
        else if (reg_addr_i == `MTF_ADDR_FIADDR) reg_rdata_o <= fault_iaddr_q;
        else if (reg_addr_i == `MTF_ADDR_FEA) reg_rdata_o <= fault_ea_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  real_pass_a: assert property (acc && !xen |=> resp_valid_o &&
      resp_pa_o == $past(req_effective_addr_i)) else $error("real mode address changed");
  real_quiet_a: assert property (acc && !req_fetch_i && !data_xlate_enable_i |=>
      !resp_data_storage_fault_o) else $error("data fault with translation off");
  fetch_dstore_a: assert property (acc && req_fetch_i && xen && !bat_hit && sr[`MTF_SEG_T]
      |=> resp_instr_storage_fault_o && srs_q[`MTF_CAUSE_NOEXEC]) else $error("no fetch fault");
  data_dstore_a: assert property (acc && !req_fetch_i && xen && !bat_hit && sr[`MTF_SEG_T]
      |=> resp_data_storage_fault_o && dfc_q[`MTF_CAUSE_DSTORE]) else $error("no data fault");
  walk_stall_a: assert property (state_q == MTF_WALK |-> busy_o && walk_req_o)
      else $error("walk without stall");
  page_fault_a: assert property (walk_miss |=> resp_valid_o &&
      (srs_q[`MTF_CAUSE_PGFLT] || dfc_q[`MTF_CAUSE_PGFLT])) else $error("page fault lost");
  retry_hit_a: assert property (walk_fill |=> state_q == MTF_RETRY ##0 tlb_hit)
      else $error("retry missed");
  block_wins_a: assert property (acc && xen && bat_hit |=> !busy_o && resp_valid_o)
      else $error("walk on block hit");
  fault_addr_a: assert property ($rose(resp_instr_storage_fault_o ||
      resp_data_storage_fault_o) |-> fault_iaddr_q == held_cia_q) else $error("bad fault addr");
  chg_set_a: assert property (finish && x_chg |=> chg_wr_o ##1 !chg_wr_o || !ce_i)
      else $error("changed bit not written");

endmodule // mtf_xlate
`default_nettype wire

//--- src/mtf_defines.svh
/*
  Register offsets, field positions and sizes of the translation block.
  Assumes it is included once per compilation unit by its bare name.
*/
`ifndef MTF_DEFINES_SVH
`define MTF_DEFINES_SVH
// Byte addresses on the register port
`define MTF_ADDR_SEG_BASE  8'h00
`define MTF_ADDR_IBAT_BASE 8'h40
`define MTF_ADDR_DBAT_BASE 8'h50
`define MTF_ADDR_SRS       8'h60
`define MTF_ADDR_DFC       8'h64
`define MTF_ADDR_FIADDR    8'h68
`define MTF_ADDR_FEA       8'h6c
// Cause bits, lsb-0 positions of msb-0 bits 1, 3, 4 and 5
`define MTF_CAUSE_PGFLT    30
`define MTF_CAUSE_NOEXEC   28
`define MTF_CAUSE_PROT     27
`define MTF_CAUSE_DSTORE   26
// Segment register fields
`define MTF_SEG_T          31
`define MTF_SEG_KS         30
`define MTF_SEG_KP         29
`define MTF_SEG_N          28
// Block entry fields: upper word valid bits, lower word guard
`define MTF_BLK_VS         1
`define MTF_BLK_VP         0
`define MTF_BLK_G          3
// Upper nibble of a block bank address
`define MTF_ADDR_BANK_MASK 8'hf0
`endif

//--- src/mtf_pkg.sv
/*
  Types shared by the translation block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mtf_pkg;
  // Walk path in Gray order: idle, walk, retry
  typedef enum logic [1:0] {
    MTF_IDLE  = 2'b00,
    MTF_WALK  = 2'b01,
    MTF_RETRY = 2'b11
  } mtf_state_t;

  // One cached page translation
  typedef struct packed {
    logic        valid;
    logic [39:0] tag;
    logic [19:0] rpn;
    logic [1:0]  pp;
    logic        g;
    logic        c;
  } mtf_tlb_t;
endpackage

//--- tb/mtf_walker_model.sv
/*
  Behavioural page table walker on the far side of the translation block.
  Assumes one clock and that the bench sets the cfg inputs before a walk.
*/
`timescale 1ns/10ps
`default_nettype none

module mtf_walker_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        walk_req_i,
  input  wire logic        cfg_found_i,
  input  wire logic [19:0] cfg_rpn_i,
  input  wire logic [1:0]  cfg_pp_i,
  input  wire logic        cfg_g_i,
  input  wire logic        cfg_c_i,
  input  wire logic [3:0]  cfg_delay_i,
  output logic             walk_done_o,
  output logic             walk_found_o,
  output logic [19:0]      walk_rpn_o,
  output logic [1:0]       walk_pp_o,
  output logic             walk_g_o,
  output logic             walk_c_o
);
  logic [3:0] cnt_q;
  logic       served_q;

  // One answer per search; served_q blocks a second pulse while req lingers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q       <= 4'h0;
      served_q    <= 1'b0;
      walk_done_o <= 1'b0;
    end else begin
      walk_done_o <= 1'b0;
      if (!walk_req_i) begin
        cnt_q    <= 4'h0;
        served_q <= 1'b0;
      end else if (!served_q) begin
        if (cnt_q == cfg_delay_i) begin
          walk_done_o <= 1'b1;
          served_q    <= 1'b1;
        end else
          cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  //////////////////////////////////////////////////
  // Fields valid only with done; inverted otherwise so stale data never match
  assign walk_found_o = walk_done_o ? cfg_found_i : ~cfg_found_i;
  assign walk_rpn_o   = walk_done_o ? cfg_rpn_i : ~cfg_rpn_i;
  assign walk_pp_o    = walk_done_o ? cfg_pp_i : ~cfg_pp_i;
  assign walk_g_o     = walk_done_o ? cfg_g_i : ~cfg_g_i;
  assign walk_c_o     = walk_done_o ? cfg_c_i : ~cfg_c_i;
endmodule // mtf_walker_model
`default_nettype wire

//--- tb/mtf_xlate_tb.sv
/*
  Self-checking bench: real mode, block and page paths, walks, fault causes.
  Assumes the walker model is compiled first and the defines header is found.
*/
`timescale 1ns/10ps
`default_nettype none
`include "mtf_defines.svh"

module mtf_xlate_tb;
  logic        clk, rst, ce, ie, de, rv, rf, rs, ru, rd, wr;
  logic [31:0] ea, ia, wd, pa, rdata, r_pa;
  logic [7:0]  ra;
  logic        busy, resp_v, ifl, dfl, wreq, wdone, wfound, wg, wc, chg;
  logic [51:0] wva, chgva, r_wva, r_chgva;
  logic [19:0] wrpn, w_rpn;
  logic [1:0]  wpp, w_pp;
  logic        w_found, w_g, w_c, r_if, r_df, r_chg, r_walk, r_busy, r_rv;
  logic [3:0]  w_dly;
  int          fail_count, checks;

  mtf_xlate mtf_xlate_inst (.clk_i(clk), .rst_i(rst), .ce_i(ce),
    .instr_xlate_enable_i(ie), .data_xlate_enable_i(de), .req_valid_i(rv),
    .req_fetch_i(rf), .req_store_i(rs), .req_user_i(ru),
    .req_effective_addr_i(ea), .req_instr_addr_i(ia), .busy_o(busy),
    .resp_valid_o(resp_v), .resp_pa_o(pa), .resp_instr_storage_fault_o(ifl),
    .resp_data_storage_fault_o(dfl), .walk_req_o(wreq), .walk_va_o(wva),
    .walk_done_i(wdone), .walk_found_i(wfound), .walk_rpn_i(wrpn), .walk_pp_i(wpp),
    .walk_g_i(wg), .walk_c_i(wc), .chg_wr_o(chg), .chg_va_o(chgva),
    .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata));

  mtf_walker_model mtf_walker_model_inst (.clk_i(clk), .rst_i(rst), .walk_req_i(wreq),
    .cfg_found_i(w_found), .cfg_rpn_i(w_rpn), .cfg_pp_i(w_pp), .cfg_g_i(w_g),
    .cfg_c_i(w_c), .cfg_delay_i(w_dly), .walk_done_o(wdone), .walk_found_o(wfound),
    .walk_rpn_o(wrpn), .walk_pp_o(wpp), .walk_g_o(wg), .walk_c_o(wc));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  //////////////////////////////////////////////////
  task automatic print_verdict();
    if (fail_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [51:0] seen, input logic [51:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Segment contents: 2 direct-store, 5 no-execute, 6 supervisor key set
  function automatic logic [31:0] sr_val(input int k);
    case (k)
      2: return 32'h8000_0002;
      5: return 32'h1000_0005;
      6: return 32'h4000_0006;
      default: return {8'h00, 20'habcde, 4'(k)};
    endcase
  endfunction

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  // One access; waits bounded for the answer, noting walk and busy on the way
  task automatic acc(input logic f, input logic s, input logic [31:0] e);
    @(posedge clk);
    rv <= 1'b1;
    rf <= f;
    rs <= s;
    ea <= e;
    ia <= $urandom;
    @(posedge clk);
    rv <= 1'b0;
    r_walk = 1'b0;
    r_busy = 1'b0;
    r_rv = 1'b0;
    for (int n = 0; n < 40 && !r_rv; n++) begin
      @(negedge clk);
      if (wreq) r_wva = wva;
      r_walk |= wreq;
      r_busy |= busy;
      r_rv = resp_v;
      r_pa = pa;
      r_if = ifl;
      r_df = dfl;
      r_chg = chg;
      r_chgva = chgva;
    end
    chk("resp_valid", r_rv, 1'b1);
  endtask

  // Clear causes, take a fault, then check the cause word and saved address
  task automatic fcase(input logic f, input logic s, input logic [31:0] e, input int b);
    logic [31:0] v;
    wreg(`MTF_ADDR_SRS, 32'hffff_ffff);
    wreg(`MTF_ADDR_DFC, 32'hffff_ffff);
    acc(f, s, e);
    chk("fault", f ? r_if : r_df, 1'b1);
    rreg(f ? `MTF_ADDR_SRS : `MTF_ADDR_DFC, v);
    chk("cause", v, 32'h1 << b);
    rreg(`MTF_ADDR_FIADDR, v);
    chk("fault_ia", v, ia);
  endtask

  //////////////////////////////////////////////////
  initial begin
    logic [31:0] v, e, s;
    int          k;
    {rst, ce, ie, de, rv, rf, rs, ru, rd, wr} = 10'b1100000000;
    {ea, ia, wd, ra} = '0;
    {w_found, w_rpn, w_pp, w_g, w_c, w_dly} = {1'b1, 20'h0, 2'b10, 1'b0, 1'b1, 4'h0};
    void'($urandom(69259));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rreg(`MTF_ADDR_SRS, v);
    chk("srs_reset", v, 32'h0);
    rreg(8'h80, v);
    chk("unmapped", v, 32'h0);
    for (int i = 0; i < 16; i++) wreg(8'(i * 4), sr_val(i));
    wreg(`MTF_ADDR_IBAT_BASE, 32'h2000_0002);
    wreg(8'h44, 32'h8000_0002);
    wreg(8'h48, 32'h3000_0002);
    wreg(8'h4c, 32'h9000_000a);
    wreg(`MTF_ADDR_DBAT_BASE, 32'h4000_0002);
    wreg(8'h54, 32'ha000_0001);
    // Real mode, including a data access into a direct-store segment
    repeat (4) begin
      e = $urandom;
      acc(1'b1, 1'b0, e);
      chk("real_pa", r_pa, e);
      acc(1'b0, 1'b1, {16'h2800, e[15:0]});
      chk("real_data_pa", r_pa, {16'h2800, e[15:0]});
      chk("real_nofault", r_df, 1'b0);
    end
    ie <= 1'b1;
    de <= 1'b1;
    // Block hits, the first over a direct-store segment
    acc(1'b1, 1'b0, 32'h2000_1234);
    chk("blk_pa", r_pa, 32'h8000_1234);
    chk("blk_nofault", r_if, 1'b0);
    acc(1'b0, 1'b0, 32'h4000_0044);
    chk("blk_rd_pa", r_pa, 32'ha000_0044);
    fcase(1'b0, 1'b1, 32'h4000_0048, `MTF_CAUSE_PROT);
    fcase(1'b1, 1'b0, 32'h3000_0010, `MTF_CAUSE_NOEXEC);
    fcase(1'b1, 1'b0, 32'h5000_0000, `MTF_CAUSE_NOEXEC);
    fcase(1'b1, 1'b0, 32'h2800_0000, `MTF_CAUSE_NOEXEC);
    fcase(1'b0, 1'b0, 32'h2800_0000, `MTF_CAUSE_DSTORE);
    // Random pages: miss and walk, hit in same TLB, miss in the other TLB
    repeat (8) begin
      k = $urandom_range(7, 15);
      e = {4'(k), 28'($urandom)};
      s = sr_val(k);
      w_rpn <= 20'($urandom);
      w_dly <= 4'($urandom_range(0, 6));
      acc(1'b1, 1'b0, e);
      chk("walk", r_walk, 1'b1);
      chk("busy", r_busy, 1'b1);
      chk("walk_va", r_wva, {s[23:0], e[27:0]});
      chk("page_pa", r_pa, {w_rpn, e[11:0]});
      acc(1'b1, 1'b0, e ^ 32'h0000_0abc);
      chk("hit_nowalk", r_walk, 1'b0);
      chk("hit_pa", r_pa, {w_rpn, e[11:0] ^ 12'habc});
      acc(1'b0, 1'b0, e);
      chk("dtlb_walk", r_walk, 1'b1);
    end
    // Store to a clean page marks it once
    w_c <= 1'b0;
    e = {4'h9, 28'($urandom)};
    s = sr_val(9);
    acc(1'b0, 1'b1, e);
    chk("chg_wr", r_chg, 1'b1);
    chk("chg_va", r_chgva, {s[23:0], e[27:0]});
    acc(1'b0, 1'b1, e);
    chk("chg_once", r_chg, 1'b0);
    w_c <= 1'b1;
    w_pp <= 2'b01;
    fcase(1'b0, 1'b1, 32'h6000_1000, `MTF_CAUSE_PROT);
    w_pp <= 2'b10;
    w_g <= 1'b1;
    fcase(1'b1, 1'b0, 32'h7123_4000, `MTF_CAUSE_NOEXEC);
    w_g <= 1'b0;
    w_found <= 1'b0;
    fcase(1'b1, 1'b0, 32'h8abc_d000, `MTF_CAUSE_PGFLT);
    fcase(1'b0, 1'b0, 32'h8abc_e000, `MTF_CAUSE_PGFLT);
    print_verdict();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
endmodule // mtf_xlate_tb
`default_nettype wire
